// ---- frg_pkg.sv ----
//------------------------------------------------------------------------------
// Purpose: Constants and carrier types for the reset/fault output gating block
// Assumes: APB register access, 32-bit data, byte addresses below
// Notes:   Gate bit 1 passes a source, 0 blocks it
//------------------------------------------------------------------------------
package frg_pkg;

    // -------------------------------------------------------------------------
    // Bus geometry
    // -------------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // -------------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] MISC_RST_GATE_ADDR = 16'h2044;
    localparam logic [ADDR_W-1:0] AUX_RST_GATE_ADDR  = 16'h2048;
    localparam logic [ADDR_W-1:0] UV_FLT_GATE_ADDR   = 16'h204c;
    localparam logic [ADDR_W-1:0] OV_FLT_GATE_ADDR   = 16'h2050;
    localparam logic [ADDR_W-1:0] WARN_FLT_GATE_ADDR = 16'h2054;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR    = 16'h2070;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR      = 16'h2074;
    localparam logic [ADDR_W-1:0] PIN_STATE_ADDR     = 16'h2078;

    // -------------------------------------------------------------------------
    // Field widths and positions
    // -------------------------------------------------------------------------
    localparam int MISC_W = 23;
    localparam int AUX_W  = 19;
    localparam int UV_W   = 15;
    localparam int OV_W   = 14;
    localparam int WARN_W = 14;
    localparam int IRQ_W  = 2;

    localparam int MISC_WD0_BIT      = 0;
    localparam int MISC_WD1_BIT      = 1;
    localparam int MISC_QA_WD_BIT    = 2;
    localparam int MISC_SERIAL_LO    = 3;
    localparam int MISC_SERIAL_HI    = 8;
    localparam int MISC_ECC_BIT      = 19;
    localparam int MISC_SHR_CRC_BIT  = 20;
    localparam int MISC_CLKMON_BIT   = 21;
    localparam int MISC_WDI_PULSE_BIT = 22;
    localparam int IRQ_RESET_BIT     = 0;
    localparam int IRQ_FAULT_BIT     = 1;

    // -------------------------------------------------------------------------
    // Reset values and writable-bit masks
    // -------------------------------------------------------------------------
    localparam logic [DATA_W-1:0] MISC_RST_VAL = 32'h0000_0004;
    localparam logic [DATA_W-1:0] AUX_RST_VAL  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] UV_RST_VAL   = 32'h0000_4fff;
    localparam logic [DATA_W-1:0] OV_RST_VAL   = 32'h0000_0fff;
    localparam logic [DATA_W-1:0] WARN_RST_VAL = 32'h0000_0000;
    localparam logic [DATA_W-1:0] IRQ_RST_VAL  = 32'h0000_0000;

    localparam logic [DATA_W-1:0] MISC_WR_MASK = 32'h007f_01ff;
    localparam logic [DATA_W-1:0] AUX_WR_MASK  = 32'h0007_ffff;
    localparam logic [DATA_W-1:0] UV_WR_MASK   = 32'h0000_7fff;
    localparam logic [DATA_W-1:0] OV_WR_MASK   = 32'h0000_3fff;
    localparam logic [DATA_W-1:0] WARN_WR_MASK = 32'h0000_3fff;
    localparam logic [DATA_W-1:0] IRQ_WR_MASK  = 32'h0000_0003;

    // -------------------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [MISC_W-1:0] misc;
        logic [AUX_W-1:0]  aux;
    } frg_live_t;

    typedef struct packed {
        logic [UV_W-1:0]   uv;
        logic [OV_W-1:0]   ov;
        logic [WARN_W-1:0] warn;
    } frg_latch_t;

endpackage : frg_pkg

// ---- frg_gate.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
// Purpose: APB-programmed gating of supervisory events onto reset/fault pins
// Assumes: Status and latch flags come from logic on CLK, no synchroniser
// Notes:   Zero-wait APB slave; PREADY follows CE so a frozen block stalls
//------------------------------------------------------------------------------
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module frg_gate
    import frg_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [DATA_W-1:0] PWDATA,
    input  wire logic [STRB_W-1:0] PSTRB,
    output logic      [DATA_W-1:0] PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire frg_live_t         LIVE,
    input  wire frg_latch_t        LATCH,
    output logic                   SYS_RESET_N,
    output logic                   SYS_FAULT_N,
    output logic                   IRQ
);

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Byte-lane merge restricted to implemented bits, so reserved stay zero
    function automatic logic [DATA_W-1:0] wr_merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] wdat,
        input logic [STRB_W-1:0] strb,
        input logic [DATA_W-1:0] wmask
    );
        logic [DATA_W-1:0] lane;
        lane = '0;
        for (int i = 0; i < STRB_W; i++) begin
            lane[i*8 +: 8] = {8{strb[i]}};
        end
        return (old_v & ~(lane & wmask)) | (wdat & lane & wmask);
    endfunction : wr_merge

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] reg_addr
    );
        return a[ADDR_W-1:2] == reg_addr[ADDR_W-1:2];
    endfunction : hit

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic [DATA_W-1:0] misc_q;
    logic [DATA_W-1:0] aux_q;
    logic [DATA_W-1:0] uv_q;
    logic [DATA_W-1:0] ov_q;
    logic [DATA_W-1:0] warn_q;
    logic [DATA_W-1:0] irq_stat_q;
    logic [DATA_W-1:0] irq_mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic              reset_act_q;
    logic              fault_act_q;
    logic              reset_act_d;
    logic              fault_act_d;
    logic              mapped;
    logic              wr_en;
    logic              setup;
    logic [IRQ_W-1:0]  irq_evt;
    logic [DATA_W-1:0] irq_set;
    logic [DATA_W-1:0] rd_mux;

    // -------------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------------
    always_comb begin
        mapped = hit(PADDR, MISC_RST_GATE_ADDR)
              || hit(PADDR, AUX_RST_GATE_ADDR)
              || hit(PADDR, UV_FLT_GATE_ADDR)   || hit(PADDR, OV_FLT_GATE_ADDR)
              || hit(PADDR, WARN_FLT_GATE_ADDR) || hit(PADDR, IRQ_STATUS_ADDR)
              || hit(PADDR, IRQ_MASK_ADDR)      || hit(PADDR, PIN_STATE_ADDR);
    end

    assign PREADY  = CE;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign setup   = CE && PSEL && !PENABLE;
    assign wr_en   = CE && PSEL && PENABLE && PWRITE && mapped;

    // Read data is captured in the setup cycle so PRDATA comes from a flop
    always_comb begin
        rd_mux = '0;
        if (hit(PADDR, MISC_RST_GATE_ADDR)) begin
            rd_mux = misc_q & MISC_WR_MASK;
        end else if (hit(PADDR, AUX_RST_GATE_ADDR)) begin
            rd_mux = aux_q & AUX_WR_MASK;
        end else if (hit(PADDR, UV_FLT_GATE_ADDR)) begin
            rd_mux = uv_q & UV_WR_MASK;
        end else if (hit(PADDR, OV_FLT_GATE_ADDR)) begin
            rd_mux = ov_q & OV_WR_MASK;
        end else if (hit(PADDR, WARN_FLT_GATE_ADDR)) begin
            rd_mux = warn_q & WARN_WR_MASK;
        end else if (hit(PADDR, IRQ_STATUS_ADDR)) begin
            rd_mux = irq_stat_q;
        end else if (hit(PADDR, IRQ_MASK_ADDR)) begin
            rd_mux = irq_mask_q;
        end else if (hit(PADDR, PIN_STATE_ADDR)) begin
            rd_mux[IRQ_RESET_BIT] = reset_act_q;
            rd_mux[IRQ_FAULT_BIT] = fault_act_q;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= '0;
        end else if (setup && !PWRITE) begin
            rdata_q <= rd_mux;
        end
    end

    assign PRDATA = rdata_q;

    // -------------------------------------------------------------------------
    // Reset gating registers
    // -------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            misc_q <= MISC_RST_VAL;
        end else if (wr_en && hit(PADDR, MISC_RST_GATE_ADDR)) begin
            misc_q <= wr_merge(misc_q, PWDATA, PSTRB, MISC_WR_MASK);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aux_q <= AUX_RST_VAL;
        end else if (wr_en && hit(PADDR, AUX_RST_GATE_ADDR)) begin
            aux_q <= wr_merge(aux_q, PWDATA, PSTRB, AUX_WR_MASK);
        end
    end

    // -------------------------------------------------------------------------
    // Fault gating registers
    // -------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            uv_q <= UV_RST_VAL;
        end else if (wr_en && hit(PADDR, UV_FLT_GATE_ADDR)) begin
            uv_q <= wr_merge(uv_q, PWDATA, PSTRB, UV_WR_MASK);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ov_q <= OV_RST_VAL;
        end else if (wr_en && hit(PADDR, OV_FLT_GATE_ADDR)) begin
            ov_q <= wr_merge(ov_q, PWDATA, PSTRB, OV_WR_MASK);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            warn_q <= WARN_RST_VAL;
        end else if (wr_en && hit(PADDR, WARN_FLT_GATE_ADDR)) begin
            warn_q <= wr_merge(warn_q, PWDATA, PSTRB, WARN_WR_MASK);
        end
    end

    // -------------------------------------------------------------------------
    // Output gating
    // -------------------------------------------------------------------------
    // Reset pin follows live flags; fault pin follows latched flags
    always_comb begin
        reset_act_d = |(misc_q[MISC_W-1:0] & LIVE.misc)
                   || |(aux_q[AUX_W-1:0] & LIVE.aux);
        fault_act_d = |(uv_q[UV_W-1:0] & LATCH.uv)
                   || |(ov_q[OV_W-1:0] & LATCH.ov)
                   || |(warn_q[WARN_W-1:0] & LATCH.warn);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            reset_act_q <= 1'b0;
            fault_act_q <= 1'b0;
        end else if (CE) begin
            reset_act_q <= reset_act_d;
            fault_act_q <= fault_act_d;
        end
    end

    assign SYS_RESET_N = !reset_act_q;
    assign SYS_FAULT_N = !fault_act_q;

    // -------------------------------------------------------------------------
    // Interrupt
    // -------------------------------------------------------------------------
    // Events are the assertion edges of each pin; set wins over a W1C clear
    assign irq_evt[IRQ_RESET_BIT] = reset_act_d && !reset_act_q;
    assign irq_evt[IRQ_FAULT_BIT] = fault_act_d && !fault_act_q;
    assign irq_set = {{(DATA_W-IRQ_W){1'b0}}, irq_evt};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_q <= IRQ_RST_VAL;
        end else if (CE) begin
            if (wr_en && hit(PADDR, IRQ_STATUS_ADDR)) begin
                irq_stat_q <= (irq_stat_q
                             & ~wr_merge('0, PWDATA, PSTRB, IRQ_WR_MASK))
                             | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_q <= IRQ_RST_VAL;
        end else if (wr_en && hit(PADDR, IRQ_MASK_ADDR)) begin
            irq_mask_q <= wr_merge(irq_mask_q, PWDATA, PSTRB, IRQ_WR_MASK);
        end
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    logic first_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    property p_gate_blocks;
        @(posedge CLK) disable iff (!RST_N)
        (CE && (misc_q[MISC_W-1:0] & LIVE.misc) == '0
            && (aux_q[AUX_W-1:0] & LIVE.aux) == '0) |=> SYS_RESET_N;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks)
        else $error("reset pin asserted with every source blocked");

    property p_reset_follows;
        @(posedge CLK) disable iff (!RST_N)
        (CE && |(aux_q[AUX_W-1:0] & LIVE.aux)) |=> !SYS_RESET_N;
    endproperty
    a_reset_follows: assert property (p_reset_follows)
        else $error("gated live flag did not assert reset pin");

    property p_fault_follows;
        @(posedge CLK) disable iff (!RST_N)
        CE ##0 (fault_act_d != fault_act_q)
            |=> (SYS_FAULT_N == !$past(fault_act_d));
    endproperty
    a_fault_follows: assert property (p_fault_follows)
        else $error("fault pin did not follow gated latch flags");

    property p_misc_defaults;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> misc_q[MISC_QA_WD_BIT:MISC_WD0_BIT] == 3'h4;
    endproperty
    a_misc_defaults: assert property (p_misc_defaults)
        else $error("watchdog reset gates wrong after reset");

    property p_serial_defaults;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> misc_q[MISC_SERIAL_HI:MISC_SERIAL_LO] == 6'h0;
    endproperty
    a_serial_defaults: assert property (p_serial_defaults)
        else $error("serial error reset gates not cleared after reset");

    property p_monitor_defaults;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> misc_q[MISC_CLKMON_BIT:MISC_ECC_BIT] == 3'h0;
    endproperty
    a_monitor_defaults: assert property (p_monitor_defaults)
        else $error("monitor reset gates not cleared after reset");

    property p_pulse_default;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> !misc_q[MISC_WDI_PULSE_BIT];
    endproperty
    a_pulse_default: assert property (p_pulse_default)
        else $error("pulse error reset gate not cleared after reset");

    property p_aux_default;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> aux_q == 32'h0;
    endproperty
    a_aux_default: assert property (p_aux_default)
        else $error("aux reset gates not cleared after reset");

    property p_fault_defaults;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> (uv_q == 32'h4fff && ov_q == 32'h0fff);
    endproperty
    a_fault_defaults: assert property (p_fault_defaults)
        else $error("under/overvolt fault gates wrong after reset");

    property p_warn_write;
        @(posedge CLK) disable iff (!RST_N)
        (wr_en && PADDR == 16'h2054 && PSTRB == 4'hf)
            |=> warn_q == ($past(PWDATA) & 32'h3fff);
    endproperty
    a_warn_write: assert property (p_warn_write)
        else $error("write to warning gate address not stored");

    property p_warn_default;
        @(posedge CLK) disable iff (!RST_N)
        first_q |-> warn_q == 32'h0;
    endproperty
    a_warn_default: assert property (p_warn_default)
        else $error("warning gates not cleared after reset");

    property p_reserved_zero;
        @(posedge CLK) disable iff (!RST_N)
        (misc_q & 32'hff80_fe00) == 32'h0 && (aux_q & 32'hfff8_0000) == 32'h0
            && (uv_q & 32'hffff_8000) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved gate bits became set");

    c_reset_pin: cover property (@(posedge CLK) disable iff (!RST_N)
        $fell(SYS_RESET_N));
    c_fault_pin: cover property (@(posedge CLK) disable iff (!RST_N)
        $fell(SYS_FAULT_N));
    c_irq: cover property (@(posedge CLK) disable iff (!RST_N) $rose(IRQ));

endmodule : frg_gate

// ---- frg_proc_model.sv ----
//------------------------------------------------------------------------------
// Purpose: System processor model watching the reset and fault pins
// Assumes: Both pins are push-pull levels on the system clock
// Notes:   Only counts pin assertions; it never drives the block
//------------------------------------------------------------------------------
`timescale 1ns/1ps

module frg_proc_model (
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   reset_n_pin,
    input  wire logic   fault_n_pin,
    output int unsigned reset_hits,
    output int unsigned fault_hits
);
    logic reset_n_q;
    logic fault_n_q;

    // -------------------------------------------------------------------------
    // Edge counting
    // -------------------------------------------------------------------------
    // A processor reacts to each falling edge, not to the held level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_n_q  <= 1'b1;
            fault_n_q  <= 1'b1;
            reset_hits <= 0;
            fault_hits <= 0;
        end else begin
            reset_n_q <= reset_n_pin;
            fault_n_q <= fault_n_pin;
            if (reset_n_q && !reset_n_pin) begin
                reset_hits <= reset_hits + 1;
            end
            if (fault_n_q && !fault_n_pin) begin
                fault_hits <= fault_hits + 1;
            end
        end
    end
endmodule : frg_proc_model

// ---- frg_gate_tb_top.sv ----
//------------------------------------------------------------------------------
// Purpose: Self-checking bench for the reset/fault pin gating block
// Assumes: APB slave answers while CE is high, one-cycle flag-to-pin latency
// Notes:   CE drops once mid-transfer to check the stall and the freeze
//------------------------------------------------------------------------------
`timescale 1ns/1ps

module frg_gate_tb_top
    import frg_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              ce = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [STRB_W-1:0] pstrb = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    frg_live_t         live = '0;
    frg_latch_t        latch = '0;
    logic              sys_reset_n;
    logic              sys_fault_n;
    logic              irq;
    int unsigned       reset_hits;
    int unsigned       fault_hits;
    int                miscompares = 0;
    int                tests_run = 0;
    int                cycles = 0;
    logic [DATA_W-1:0] rdat;
    logic              rerr;
    logic [ADDR_W-1:0] reg_addr [5] = '{MISC_RST_GATE_ADDR,
        AUX_RST_GATE_ADDR, UV_FLT_GATE_ADDR, OV_FLT_GATE_ADDR,
        WARN_FLT_GATE_ADDR};
    logic [DATA_W-1:0] rst_exp [5] = '{32'h0000_0004, 32'h0000_0000,
        32'h0000_4fff, 32'h0000_0fff, 32'h0000_0000};
    logic [DATA_W-1:0] rw_exp [5] = '{32'h007f_01ff, 32'h0007_ffff,
        32'h0000_7fff, 32'h0000_3fff, 32'h0000_3fff};
    int unsigned       g_reg [9] = '{0, 0, 0, 0, 1, 1, 2, 3, 4};
    int unsigned       g_bit [9] = '{22, 21, 2, 8, 18, 0, 14, 13, 0};

    always #2.5 clk = ~clk;

    frg_gate frg_gate_inst (
        .CLK         (clk),
        .RST_N       (rst_n),
        .CE          (ce),
        .PSEL        (psel),
        .PENABLE     (penable),
        .PWRITE      (pwrite),
        .PADDR       (paddr),
        .PWDATA      (pwdata),
        .PSTRB       (pstrb),
        .PRDATA      (prdata),
        .PREADY      (pready),
        .PSLVERR     (pslverr),
        .LIVE        (live),
        .LATCH       (latch),
        .SYS_RESET_N (sys_reset_n),
        .SYS_FAULT_N (sys_fault_n),
        .IRQ         (irq)
    );

    frg_proc_model frg_proc_model_inst (
        .clk         (clk),
        .rst_n       (rst_n),
        .reset_n_pin (sys_reset_n),
        .fault_n_pin (sys_fault_n),
        .reset_hits  (reset_hits),
        .fault_hits  (fault_hits)
    );

    // -------------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Request held until the edge that samples PREADY high
    task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d,
                            input logic [STRB_W-1:0] s);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp);
        apb_xfer(1'b0, a, 32'h0, 4'h0);
        check(nm, rdat, exp);
        check("mapped error flag", {31'h0, rerr}, 32'h0);
    endtask : rd_chk

    task automatic set_flag(input int unsigned id, input int unsigned b,
                            input logic v);
        case (id)
            0: live.misc[b] <= v;
            1: live.aux[b] <= v;
            2: latch.uv[b] <= v;
            3: latch.ov[b] <= v;
            default: latch.warn[b] <= v;
        endcase
    endtask : set_flag

    function automatic logic [31:0] pin(input int unsigned id);
        return {31'h0, (id < 2) ? sys_reset_n : sys_fault_n};
    endfunction : pin

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        check("reset pin idle", {31'h0, sys_reset_n}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            rd_chk("gate reset value", reg_addr[i], rst_exp[i]);
        end
        for (int i = 0; i < 5; i++) begin
            apb_xfer(1'b1, reg_addr[i], 32'hffff_ffff, 4'hf);
            rd_chk("writable bits", reg_addr[i], rw_exp[i]);
        end
        // Lane 2 cleared alone, other lanes keep their ones
        apb_xfer(1'b1, AUX_RST_GATE_ADDR, 32'h0, 4'h4);
        rd_chk("byte lane write", AUX_RST_GATE_ADDR, 32'h0000_ffff);
        apb_xfer(1'b1, 16'h2060, 32'hffff_ffff, 4'hf);
        check("unmapped write error", {31'h0, rerr}, 32'h1);
        apb_xfer(1'b0, 16'h2060, 32'h0, 4'h0);
        check("unmapped read data", rdat, 32'h0);
        check("unmapped read error", {31'h0, rerr}, 32'h1);
        // Nine sources: blocked at gate 0, passed at gate 1, released after
        for (int i = 0; i < 9; i++) begin
            apb_xfer(1'b1, reg_addr[g_reg[i]], 32'h0, 4'hf);
            set_flag(g_reg[i], g_bit[i], 1'b1);
            repeat (2) @(posedge clk);
            check("pin blocked", pin(g_reg[i]), 32'h1);
            apb_xfer(1'b1, reg_addr[g_reg[i]], 32'h1 << g_bit[i], 4'hf);
            repeat (2) @(posedge clk);
            check("pin passed", pin(g_reg[i]), 32'h0);
            set_flag(g_reg[i], g_bit[i], 1'b0);
            repeat (2) @(posedge clk);
            check("pin released", pin(g_reg[i]), 32'h1);
        end
        check("reset assertions", 32'(reset_hits), 32'd6);
        check("fault assertions", 32'(fault_hits), 32'd3);
        // Interrupt: both events seen and masked; reset event unmasked and cleared
        rd_chk("irq status", IRQ_STATUS_ADDR, 32'h0000_0003);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb_xfer(1'b1, IRQ_MASK_ADDR, 32'h0000_0001, 4'hf);
        repeat (2) @(posedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        apb_xfer(1'b1, IRQ_STATUS_ADDR, 32'h0000_0001, 4'hf);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk("irq status left", IRQ_STATUS_ADDR, 32'h0000_0002);
        rd_chk("irq mask", IRQ_MASK_ADDR, 32'h0000_0001);
        // Frozen block: access stalls, pin holds, both resume together
        fork
            apb_xfer(1'b1, WARN_FLT_GATE_ADDR, 32'h0000_2000, 4'hf);
            begin
                @(posedge clk);
                ce <= 1'b0;
                live.aux[0] <= 1'b1;
                repeat (4) @(posedge clk);
                check("frozen ready", {31'h0, pready}, 32'h0);
                check("frozen reset pin", {31'h0, sys_reset_n}, 32'h1);
                ce <= 1'b1;
            end
        join
        @(posedge clk);
        check("resumed reset pin", {31'h0, sys_reset_n}, 32'h0);
        check("resumed irq", {31'h0, irq}, 32'h1);
        rd_chk("stalled wr", WARN_FLT_GATE_ADDR, 32'h0000_2000);
        rd_chk("pin state", PIN_STATE_ADDR, 32'h0000_0001);
        check("reset assertions again", 32'(reset_hits), 32'd7);
        // Reset in mid-run restores every default and idles the pins
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check("pin after reset", {31'h0, sys_reset_n}, 32'h1);
        check("irq after reset", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rd_chk("gate after reset", reg_addr[i], rst_exp[i]);
        end
        tally_and_finish();
    end
endmodule : frg_gate_tb_top
